// ---- hw/css_pkg.sv ----
// constants, types and register map of the system clock source selector
// assumes one 100 MHz clock; oscillators arrive as one-cycle enable ticks
package css_pkg;

  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SW_TIMEOUT_NS = 100000;
  localparam int SW_TIMEOUT_CYC = (SW_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int FAIL_REF_TICKS = 2;

  // register indices
  localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CLK_DIV = 2'h1;
  localparam logic [1:0] ADDR_PLL_FBD = 2'h2;
  localparam logic [1:0] ADDR_TUNE = 2'h3;

  // osc_control_reg fields
  localparam int OSC_CUR_LSB = 12;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_FAIL_BIT = 3;
  localparam int OSC_SECEN_BIT = 1;
  localparam int OSC_SWREQ_BIT = 0;

  // clock_divisor_reg fields
  localparam int DIV_POST_LSB = 12;
  localparam int DIV_RCDIV_LSB = 8;
  localparam int DIV_PLLOUT_LSB = 6;
  localparam int DIV_PLLIN_LSB = 0;

  // reset values and fixed divider settings
  localparam logic [2:0] POST_RST = 3'h0;
  localparam logic [2:0] RCDIV_RST = 3'h0;
  localparam logic [1:0] PLLOUT_RST = 2'h0;
  localparam logic [4:0] PLLIN_RST = 5'h00;
  localparam logic [8:0] PLLFB_RST = 9'h030;
  localparam logic [5:0] TUNE_RST = 6'h00;
  localparam logic [7:0] FRC_DIV16_M1 = 8'h0F;
  localparam logic [7:0] FCY_DIV_M1 = 8'h01;

  typedef enum logic [2:0] {
    SRC_FRC, SRC_FRC_PLL, SRC_PRI, SRC_PRI_PLL, SRC_SEC, SRC_SLOW_INTERNAL_RC_OSC, SRC_FRC_DIV16, SRC_FRC_DIVN
  } css_src_t;

  typedef enum logic [1:0] {
    PMODE_EXT, PMODE_STD, PMODE_FAST, PMODE_OFF
  } css_pmode_t;

  typedef struct packed {
    logic fast_internal_rc_osc;
    logic pri;
    logic sec;
    logic slow_internal_rc_osc;
  } css_osc_ticks_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } css_bus_req_t;

endpackage

// ---- hw/css_tick_div.sv ----
// divides a stream of enable ticks by (div_m1 + 1)
// assumes tick_in is a one-cycle pulse; output is registered, one cycle late
`timescale 1ns/10ps
`default_nettype none

module css_tick_div #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick_in,
  input wire logic [W-1:0] div_m1,
  output logic tick_out
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end
    else if (tick_in)
    begin
      // a shrunk divisor restarts cleanly instead of wrapping
      if (cnt_q >= div_m1)
      begin
        cnt_q <= '0;
        tick_out <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- hw/css_clock_sel.sv ----
// system clock source selector: source mux, pll rate path, dividers, switch, fail monitor
// assumes all oscillator ticks and the register port are synchronous to clk
//
// Overview of operation
// - eight system clock choices, selected by a three-bit source code
// - fast rc divided by 2 up to 256, field bits 10:8 of divisor register
// - software trims the fast rc through a tuning register driven to the oscillator
// - primary mode: standard crystal, fast crystal up to 40 MHz, or external clock
// - secondary oscillator runs from its own 32.768 kHz crystal pins
// - slow rc tick is the watchdog and fail monitor reference
// - fast rc or primary may be routed through the pll
// - at power-on the source comes from initial source and primary mode fields
// - configuration fields are nonvolatile and sampled at reset release
// - erased configuration bits start from a fast rc selection
// - the two configuration fields together give twelve clock modes
// - postscaled system clock divided by two gives instruction and peripheral clocks
// - fail monitor detects a lost system clock and falls back to fast rc
// - the system clock can be switched at run time
// - programmable postscaler lowers the system clock rate
// - source codes: 000 frc ... 111 frc divided by n
// - software sets switch request; hardware switches and clears it when done
// - clock fail flag set by monitor, stays until software clears it
// - pll divides by 2..33, multiplies by feedback, divides by 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none

module css_clock_sel
  import css_pkg::*;
#(
  parameter int SW_TIMEOUT_CYC_P = SW_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire css_bus_req_t bus,
  output logic [15:0] rdata_q,
  input wire css_osc_ticks_t osc,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_mode_cfg,
  input wire logic fail_mon_en,
  output logic sys_tick_q,
  output logic instr_tick_q,
  output logic periph_tick_q,
  output logic wdt_ref_tick_q,
  output css_pmode_t primary_mode_q,
  output logic sec_osc_en_q,
  output logic [5:0] frc_trim_q,
  output logic clock_fail_q
);

  localparam int TW = $clog2(SW_TIMEOUT_CYC_P + 1);
  localparam int LW = $clog2(PLL_LOCK_CYC + 1);

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_NEW} css_sw_state_t;

  css_sw_state_t sw_state_q;
  css_src_t cur_src_q;
  css_src_t new_src_q;
  logic cfg_taken_q;
  logic swreq_q;
  logic sec_en_q;
  logic [2:0] post_q;
  logic [2:0] rcdiv_q;
  logic [1:0] pllout_q;
  logic [4:0] pllin_q;
  logic [8:0] pllfb_q;
  logic [TW-1:0] sw_tmr_q;
  logic [2:0] fail_cnt_q;
  logic [11:0] pll_acc_q;
  logic [LW-1:0] lock_cnt_q;
  logic pll_lock_q;
  logic pll_tick_q;
  logic frc_divn_tick;
  logic frc_div16_tick;
  logic sys_raw_tick;
  logic post_tick;
  logic fcy_tick;
  logic sw_done;
  logic fail_hit;
  logic wr_osc;
  logic wr_div;
  logic wr_fbd;
  css_src_t pll_target;
  logic pll_use;
  logic pll_in;
  logic [8:0] pll_den;
  logic [9:0] pll_m;
  logic [12:0] pll_sum;
  logic pll_fire;
  logic [15:0] rd_mux;

  // 2^e - 1, for power-of-two divider settings
  function automatic logic [7:0] pow2_m1(input logic [3:0] e);
    logic [8:0] p;
    p = 9'h001 << e;
    return 8'(p - 9'h001);
  endfunction

  // tick of a given source code
  function automatic logic src_tick(input css_src_t s, input css_osc_ticks_t o, input logic pll_t,
                                    input logic d16, input logic dn, input logic sec_on);
    case (s)
      SRC_FRC: src_tick = o.fast_internal_rc_osc;
      SRC_FRC_PLL: src_tick = pll_t;
      SRC_PRI: src_tick = o.pri;
      SRC_PRI_PLL: src_tick = pll_t;
      SRC_SEC: src_tick = o.sec & sec_on;
      SRC_SLOW_INTERNAL_RC_OSC: src_tick = o.slow_internal_rc_osc;
      SRC_FRC_DIV16: src_tick = d16;
      SRC_FRC_DIVN: src_tick = dn;
      default: src_tick = 1'b0;
    endcase
  endfunction

  assign wr_osc = bus.wr && (bus.addr == ADDR_OSC_CTRL);
  assign wr_div = bus.wr && (bus.addr == ADDR_CLK_DIV);
  assign wr_fbd = bus.wr && (bus.addr == ADDR_PLL_FBD);

  // register writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      post_q <= POST_RST;
      rcdiv_q <= RCDIV_RST;
      pllout_q <= PLLOUT_RST;
      pllin_q <= PLLIN_RST;
      pllfb_q <= PLLFB_RST;
      frc_trim_q <= TUNE_RST;
      sec_en_q <= 1'b0;
    end
    else
    begin
      if (wr_div)
      begin
        post_q <= bus.wdata[DIV_POST_LSB +: 3];
        rcdiv_q <= bus.wdata[DIV_RCDIV_LSB +: 3];
        pllout_q <= bus.wdata[DIV_PLLOUT_LSB +: 2];
        pllin_q <= bus.wdata[DIV_PLLIN_LSB +: 5];
      end
      if (wr_fbd)
        pllfb_q <= bus.wdata[8:0];
      if (bus.wr && (bus.addr == ADDR_TUNE))
        frc_trim_q <= bus.wdata[5:0];
      if (wr_osc)
        sec_en_q <= bus.wdata[OSC_SECEN_BIT];
    end
  end

  // switch request: software sets, hardware clears on completion or refusal
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      swreq_q <= 1'b0;
    else if (wr_osc && bus.wdata[OSC_SWREQ_BIT])
      swreq_q <= 1'b1;
    else if (sw_done)
      swreq_q <= 1'b0;
  end

  // clock fail flag: write 0 clears, a failure in the same cycle wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      clock_fail_q <= 1'b0;
    else if (fail_hit)
      clock_fail_q <= 1'b1;
    else if (wr_osc && !bus.wdata[OSC_FAIL_BIT])
      clock_fail_q <= 1'b0;
  end

  // new source selection; loaded from configuration at reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      new_src_q <= SRC_FRC;
    else if (!cfg_taken_q)
      new_src_q <= css_src_t'(initial_source_cfg);
    else if (wr_osc)
      new_src_q <= css_src_t'(bus.wdata[OSC_NEW_LSB +: 3]);
  end

  // configuration straps, caught once after reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_taken_q <= 1'b0;
      primary_mode_q <= PMODE_OFF;
    end
    else if (!cfg_taken_q)
    begin
      cfg_taken_q <= 1'b1;
      primary_mode_q <= css_pmode_t'(primary_mode_cfg);
    end
  end

  // fail monitor: count reference ticks with no system tick between them
  assign fail_hit = cfg_taken_q && fail_mon_en && osc.slow_internal_rc_osc && !sys_raw_tick
                    && (fail_cnt_q == 3'(FAIL_REF_TICKS - 1)) && (cur_src_q != SRC_FRC);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fail_cnt_q <= 3'h0;
    else if (sys_raw_tick || fail_hit || !fail_mon_en)
      fail_cnt_q <= 3'h0;
    else if (osc.slow_internal_rc_osc)
      fail_cnt_q <= fail_cnt_q + 3'h1;
  end

  // current source and switch sequencer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_src_q <= SRC_FRC;
      sw_state_q <= SW_IDLE;
      sw_tmr_q <= '0;
    end
    else if (!cfg_taken_q)
      cur_src_q <= css_src_t'(initial_source_cfg);
    else if (fail_hit)
    begin
      // fall back to the internal rc; a switch in flight restarts from idle while its request stays set
      cur_src_q <= SRC_FRC;
      sw_state_q <= SW_IDLE;
    end
    else
    begin
      case (sw_state_q)
        SW_IDLE:
        begin
          sw_tmr_q <= '0;
          if (swreq_q && !sw_done)
            sw_state_q <= SW_WAIT_NEW;
        end
        SW_WAIT_NEW:
        begin
          sw_tmr_q <= sw_tmr_q + {{(TW-1){1'b0}}, 1'b1};
          if (sw_done)
            sw_state_q <= SW_IDLE;
          // hand over only on a live tick of the new source
          if (sw_done && src_tick(new_src_q, osc, pll_tick_q, frc_div16_tick, frc_divn_tick, 1'b1)
              && (!pll_use || pll_lock_q))
            cur_src_q <= new_src_q;
        end
        default:
          sw_state_q <= SW_IDLE;
      endcase
    end
  end

  // completion: same source, forbidden pll to pll, new source alive, or timeout
  always_comb
  begin
    sw_done = 1'b0;
    if (swreq_q && cfg_taken_q)
    begin
      if (sw_state_q == SW_IDLE)
        sw_done = (new_src_q == cur_src_q)
                  || ((new_src_q == SRC_FRC_PLL) && (cur_src_q == SRC_PRI_PLL))
                  || ((new_src_q == SRC_PRI_PLL) && (cur_src_q == SRC_FRC_PLL));
      else
        sw_done = (src_tick(new_src_q, osc, pll_tick_q, frc_div16_tick, frc_divn_tick, 1'b1)
                   && (!pll_use || pll_lock_q))
                  || (sw_tmr_q == TW'(SW_TIMEOUT_CYC_P));
    end
  end

  // secondary oscillator runs when enabled, in use, or being switched to
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sec_osc_en_q <= 1'b0;
    else
      sec_osc_en_q <= sec_en_q || (cur_src_q == SRC_SEC)
                      || ((sw_state_q == SW_WAIT_NEW) && (new_src_q == SRC_SEC));
  end

  // pll rate path: in * M / (N1 * N2), at most one tick per clk
  always_comb
  begin
    pll_target = (sw_state_q == SW_WAIT_NEW) ? new_src_q : cur_src_q;
    pll_use = (pll_target == SRC_FRC_PLL) || (pll_target == SRC_PRI_PLL);
    pll_in = pll_use && ((pll_target == SRC_FRC_PLL) ? osc.fast_internal_rc_osc : osc.pri);
    pll_den = (9'({4'h0, pllin_q}) + 9'h002)
              * ((pllout_q == 2'h0) ? 9'h002 : ((pllout_q == 2'h1) ? 9'h004 : 9'h008));
    pll_m = {1'b0, pllfb_q} + 10'h002;
    pll_sum = {1'b0, pll_acc_q} + (pll_in ? {3'b000, pll_m} : 13'h0000);
    pll_fire = pll_use && (pll_sum >= {4'h0, pll_den});
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pll_acc_q <= 12'h000;
      pll_tick_q <= 1'b0;
    end
    else if (!pll_use)
    begin
      pll_acc_q <= 12'h000;
      pll_tick_q <= 1'b0;
    end
    else
    begin
      // the backlog saturates when the ratio asks for more than clk can carry
      if (pll_fire)
        pll_acc_q <= (pll_sum - {4'h0, pll_den} > 13'h0FFF) ? 12'hFFF
                     : 12'(pll_sum - {4'h0, pll_den});
      else
        pll_acc_q <= (pll_sum > 13'h0FFF) ? 12'hFFF : pll_sum[11:0];
      pll_tick_q <= pll_fire;
    end
  end

  // lock: a settle time after the pll is used and its settings stop changing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_cnt_q <= '0;
      pll_lock_q <= 1'b0;
    end
    else if (!pll_use || wr_div || wr_fbd)
    begin
      lock_cnt_q <= '0;
      pll_lock_q <= 1'b0;
    end
    else if (lock_cnt_q == LW'(PLL_LOCK_CYC))
      pll_lock_q <= 1'b1;
    else
      lock_cnt_q <= lock_cnt_q + {{(LW-1){1'b0}}, 1'b1};
  end

  css_tick_div #(.W(8)) u_frc_divn (
    .clk(clk),
    .arst_n(arst_n),
    .tick_in(osc.fast_internal_rc_osc),
    .div_m1(pow2_m1({1'b0, rcdiv_q} + 4'h1)),
    .tick_out(frc_divn_tick)
  );

  css_tick_div #(.W(8)) u_frc_div16 (
    .clk(clk),
    .arst_n(arst_n),
    .tick_in(osc.fast_internal_rc_osc),
    .div_m1(FRC_DIV16_M1),
    .tick_out(frc_div16_tick)
  );

  // the mux only moves between ticks, so a pulse is never cut or doubled
  assign sys_raw_tick = src_tick(cur_src_q, osc, pll_tick_q, frc_div16_tick, frc_divn_tick,
                                 sec_osc_en_q);

  css_tick_div #(.W(8)) u_post (
    .clk(clk),
    .arst_n(arst_n),
    .tick_in(sys_raw_tick),
    .div_m1(pow2_m1({1'b0, post_q})),
    .tick_out(post_tick)
  );

  css_tick_div #(.W(8)) u_fcy (
    .clk(clk),
    .arst_n(arst_n),
    .tick_in(post_tick),
    .div_m1(FCY_DIV_M1),
    .tick_out(fcy_tick)
  );

  // output stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sys_tick_q <= 1'b0;
      instr_tick_q <= 1'b0;
      periph_tick_q <= 1'b0;
      wdt_ref_tick_q <= 1'b0;
    end
    else
    begin
      sys_tick_q <= post_tick;
      instr_tick_q <= fcy_tick;
      periph_tick_q <= fcy_tick;
      wdt_ref_tick_q <= osc.slow_internal_rc_osc;
    end
  end

  // read mux; unmapped bits read as zero
  always_comb
  begin
    rd_mux = 16'h0000;
    case (bus.addr)
      ADDR_OSC_CTRL:
      begin
        rd_mux[OSC_CUR_LSB +: 3] = cur_src_q;
        rd_mux[OSC_NEW_LSB +: 3] = new_src_q;
        rd_mux[OSC_LOCK_BIT] = pll_lock_q;
        rd_mux[OSC_FAIL_BIT] = clock_fail_q;
        rd_mux[OSC_SECEN_BIT] = sec_en_q;
        rd_mux[OSC_SWREQ_BIT] = swreq_q;
      end
      ADDR_CLK_DIV:
      begin
        rd_mux[DIV_POST_LSB +: 3] = post_q;
        rd_mux[DIV_RCDIV_LSB +: 3] = rcdiv_q;
        rd_mux[DIV_PLLOUT_LSB +: 2] = pllout_q;
        rd_mux[DIV_PLLIN_LSB +: 5] = pllin_q;
      end
      ADDR_PLL_FBD:
        rd_mux[8:0] = pllfb_q;
      ADDR_TUNE:
        rd_mux[5:0] = frc_trim_q;
      default:
        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= 16'h0000;
    else if (bus.rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 16'h0000;
  end

endmodule

`default_nettype wire

// ---- bench/css_clock_sel_asserts.sv ----
// port assertions of the clock source selector
// assumes one clock domain; bound to every css_clock_sel
`timescale 1ns/10ps
`default_nettype none

module css_clock_sel_asserts
  import css_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire css_bus_req_t bus,
  input wire logic [15:0] rdata_q,
  input wire css_osc_ticks_t osc,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_mode_cfg,
  input wire logic fail_mon_en,
  input wire logic sys_tick_q,
  input wire logic instr_tick_q,
  input wire logic periph_tick_q,
  input wire logic wdt_ref_tick_q,
  input wire css_pmode_t primary_mode_q,
  input wire logic sec_osc_en_q,
  input wire logic [5:0] frc_trim_q,
  input wire logic clock_fail_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_wdt_ref;
    1'b1 |=> wdt_ref_tick_q == $past(osc.slow_internal_rc_osc);
  endproperty
  a_wdt_ref: assert property (p_wdt_ref) else $error("wdt ref tick wrong");
  property p_fcy_pair;
    instr_tick_q == periph_tick_q;
  endproperty
  a_fcy_pair: assert property (p_fcy_pair) else $error("instr and periph ticks differ");
  property p_instr_gap;
    instr_tick_q |=> !instr_tick_q;
  endproperty
  a_instr_gap: assert property (p_instr_gap) else $error("instr ticks back to back");
  property p_osc_layout;
    bus.rd && bus.addr == ADDR_OSC_CTRL |=> !rdata_q[15] && !rdata_q[11] && rdata_q[7:6] == 2'h0 && !rdata_q[2];
  endproperty
  a_osc_layout: assert property (p_osc_layout) else $error("osc control unused bits set");
  property p_fail_read;
    bus.rd && bus.addr == ADDR_OSC_CTRL |=> rdata_q[OSC_FAIL_BIT] == $past(clock_fail_q);
  endproperty
  a_fail_read: assert property (p_fail_read) else $error("fail bit read wrong");
  property p_fail_en;
    $rose(clock_fail_q) |-> $past(fail_mon_en);
  endproperty
  a_fail_en: assert property (p_fail_en) else $error("fail set while monitor off");
  property p_fail_hold;
    clock_fail_q && !(bus.wr && bus.addr == ADDR_OSC_CTRL) |=> clock_fail_q;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail flag dropped");
  property p_pmode;
    $changed(primary_mode_q) |-> primary_mode_q == $past(primary_mode_cfg);
  endproperty
  a_pmode: assert property (p_pmode) else $error("primary mode not from strap");
  // enable register, then the output flop: the pin follows two cycles after the write
  property p_secen;
    bus.wr && bus.addr == ADDR_OSC_CTRL && bus.wdata[OSC_SECEN_BIT] |=> ##1 sec_osc_en_q;
  endproperty
  a_secen: assert property (p_secen) else $error("secondary enable wrong");
  property p_trim;
    bus.wr && bus.addr == ADDR_TUNE |=> frc_trim_q == $past(bus.wdata[5:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not updated");
endmodule

bind css_clock_sel css_clock_sel_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .bus(bus), .rdata_q(rdata_q), .osc(osc),
  .initial_source_cfg(initial_source_cfg), .primary_mode_cfg(primary_mode_cfg), .fail_mon_en(fail_mon_en),
  .sys_tick_q(sys_tick_q), .instr_tick_q(instr_tick_q), .periph_tick_q(periph_tick_q),
  .wdt_ref_tick_q(wdt_ref_tick_q), .primary_mode_q(primary_mode_q), .sec_osc_en_q(sec_osc_en_q),
  .frc_trim_q(frc_trim_q), .clock_fail_q(clock_fail_q));
`default_nettype wire

// ---- bench/css_osc_model.sv ----
// oscillator far side: rc, crystal and external clock tick sources
// assumes ticks are one-cycle pulses launched just after a rising edge
`timescale 1ns/10ps
`default_nettype none

module css_osc_model
  import css_pkg::*;
#(
  parameter int PRI_PER = 3,
  parameter int SEC_PER = 37,
  parameter int SLOW_INTERNAL_RC_OSC_PER = 50
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stop_pri,
  output css_osc_ticks_t osc
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 16'h0000;
      osc <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      osc.fast_internal_rc_osc <= cnt_q[0];
      osc.pri <= (int'(cnt_q) % PRI_PER == 0) && !stop_pri;
      osc.sec <= int'(cnt_q) % SEC_PER == 0;
      osc.slow_internal_rc_osc <= int'(cnt_q) % SLOW_INTERNAL_RC_OSC_PER == 0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/css_clock_sel_tb.sv ----
// self-checking bench of the clock source selector
// assumes css_osc_model supplies the ticks; reads checked from a queue
`timescale 1ns/10ps
`default_nettype none
`define CSS_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module css_clock_sel_tb
  import css_pkg::*;
;
  typedef struct packed {logic [15:0] v; logic [15:0] m;} css_exp_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  css_bus_req_t bus = '0;
  logic [2:0] src_cfg = 3'h7;
  logic [1:0] pm_cfg = 2'h1;
  logic mon_en = 1'b0;
  logic stop_pri = 1'b0;
  logic [15:0] rdata_q;
  css_osc_ticks_t osc;
  logic sys_tick, instr_tick, periph_tick, wdt_tick, sec_en, fail;
  css_pmode_t pmode;
  logic [5:0] trim;
  css_exp_t exp_q[$];
  css_exp_t e;
  logic rd_d = 1'b0;
  logic [15:0] lfsr = 16'h0018;
  logic [15:0] v;
  int err_count = 0;
  int n_checks = 0;
  int n_sys = 0;
  int n_ins = 0;
  always #5 clk = ~clk;
  css_clock_sel #(.SW_TIMEOUT_CYC_P(1000)) DUT (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata_q(rdata_q),
    .osc(osc), .initial_source_cfg(src_cfg), .primary_mode_cfg(pm_cfg), .fail_mon_en(mon_en),
    .sys_tick_q(sys_tick), .instr_tick_q(instr_tick), .periph_tick_q(periph_tick), .wdt_ref_tick_q(wdt_tick),
    .primary_mode_q(pmode), .sec_osc_en_q(sec_en), .frc_trim_q(trim), .clock_fail_q(fail));
  css_osc_model u_osc (.clk(clk), .arst_n(arst_n), .stop_pri(stop_pri), .osc(osc));
  always @(posedge clk)
  begin
    rd_d <= bus.rd;
    n_sys <= n_sys + int'(sys_tick);
    n_ins <= n_ins + int'(instr_tick);
    if (rd_d)
    begin
      e = exp_q.pop_front();
      `CSS_CHK("rdata", e.v & e.m, rdata_q & e.m)
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  // mask 0 marks a poll read whose value only steers the bench
  task automatic rd(input logic [1:0] a, input logic [15:0] ev, input logic [15:0] em, output logic [15:0] got);
    exp_q.push_back('{ev, em});
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    got = rdata_q;
  endtask
  task automatic do_reset(input logic [2:0] s, input logic [1:0] p);
    arst_n <= 1'b0;
    src_cfg <= s;
    pm_cfg <= p;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic sw(input logic [2:0] s);
    int i;
    wr(ADDR_OSC_CTRL, {5'h00, s, 8'h03});
    v = 16'h0001;
    for (i = 0; i < 600 && v[0] !== 1'b0; i++)
      rd(ADDR_OSC_CTRL, 16'h0000, 16'h0000, v);
    if (v[0] !== 1'b0)
    begin
      $display("[FAIL] switch request exp 0 got %h", v[0]);
      err_count++;
      end_of_test();
    end
  endtask
  // frc ticks every 2 cycles, so rate n is ticks per 400 cycles
  task automatic rate(input logic [15:0] d, input int n);
    int s0;
    int i0;
    wr(ADDR_CLK_DIV, d);
    repeat (40) @(posedge clk);
    s0 = n_sys;
    i0 = n_ins;
    repeat (400) @(posedge clk);
    `CSS_CHK("sys rate", 1'b1, (n_sys - s0 - n) inside {-1, 0, 1})
    `CSS_CHK("instr rate", 1'b1, (n_ins - i0 - n / 2) inside {-1, 0, 1})
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    $display("[FAIL] run limit exp finished got still running");
    err_count++;
    end_of_test();
  end
  initial
  begin
    logic [2:0] seq [9] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1, 3'h3, 3'h7, 3'h3};
    logic [2:0] cfg [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
    logic [2:0] cur;
    int k;
    do_reset(3'h7, 2'h1);
    rd(ADDR_OSC_CTRL, 16'h7700, 16'hFFDF, v);
    rd(ADDR_CLK_DIV, {1'b0, POST_RST, 1'b0, RCDIV_RST, PLLOUT_RST, 1'b0, PLLIN_RST}, 16'hFFFF, v);
    rd(ADDR_PLL_FBD, {7'h00, PLLFB_RST}, 16'hFFFF, v);
    $display("test reset values done");
    for (k = 0; k < 4; k++)
    begin
      lfsr = nxt(lfsr);
      wr(ADDR_TUNE, lfsr);
      rd(ADDR_TUNE, {10'h000, lfsr[5:0]}, 16'hFFFF, v);
      wr(ADDR_CLK_DIV, lfsr);
      rd(ADDR_CLK_DIV, lfsr & 16'h77DF, 16'hFFFF, v);
      wr(ADDR_PLL_FBD, ~lfsr);
      rd(ADDR_PLL_FBD, ~lfsr & 16'h01FF, 16'hFFFF, v);
    end
    wr(ADDR_PLL_FBD, {7'h00, PLLFB_RST});
    $display("test register access done");
    rate(16'h0000, 100);
    rate(16'h0200, 25);
    rate(16'h1000, 50);
    wr(ADDR_CLK_DIV, 16'h0000);
    $display("test clock rates done");
    cur = 3'h7;
    // last entry reaches primary with pll from a non-pll source, which is allowed
    for (k = 0; k < 9; k++)
    begin
      sw(seq[k]);
      // pll to pll is refused and leaves the source alone
      if (!(seq[k] == 3'h3 && cur == 3'h1))
        cur = seq[k];
      rd(ADDR_OSC_CTRL, {1'b0, cur, 1'b0, seq[k], 8'h02}, 16'hFFDF, v);
    end
    $display("test switching done");
    sw(3'h2);
    mon_en <= 1'b1;
    stop_pri <= 1'b1;
    for (k = 0; k < 300 && fail !== 1'b1; k++)
      @(posedge clk);
    if (fail !== 1'b1)
    begin
      $display("[FAIL] clock fail flag exp 1 got %h", fail);
      err_count++;
      end_of_test();
    end
    repeat (120) @(posedge clk);
    rd(ADDR_OSC_CTRL, 16'h020A, 16'hFFDF, v);
    wr(ADDR_OSC_CTRL, 16'h0202);
    rd(ADDR_OSC_CTRL, 16'h0202, 16'hFFDF, v);
    mon_en <= 1'b0;
    stop_pri <= 1'b0;
    $display("test clock fail done");
    for (k = 0; k < 4; k++)
    begin
      do_reset(cfg[k], k[1:0]);
      rd(ADDR_OSC_CTRL, {1'b0, cfg[k], 1'b0, cfg[k], 8'h00}, 16'hFFDF, v);
      `CSS_CHK("primary mode", css_pmode_t'(k[1:0]), pmode)
    end
    $display("test straps done");
    end_of_test();
  end
endmodule
`default_nettype wire
